// ==== rtl/lpwc_wake_ctrl.sv ====
// low-power mode sequencer: wait, stop, stop recovery and wake vectors
`timescale 1ns/10ps
`include "lpwc_map.svh"
module lpwc_wake_ctrl (
  // clock and reset
  input  wire logic                      core_clk_in,
  input  wire logic                      rstn_in,
  // cpu side
  input  wire logic                      wait_instr_in,
  input  wire logic                      stop_instr_in,
  input  wire logic                      vector_fetched_in,
  output logic                           vector_valid_out,
  output logic [15:0]                    vector_addr_out,
  output logic                           reset_req_out,
  output logic                           cpu_clock_run_out,
  output logic                           system_clock_run_out,
  output lpwc_pkg::lpwc_state_t          state_out,
  // reset sources
  input  wire logic                      ext_reset_n_in,
  input  wire logic                      watchdog_timeout_in,
  input  wire logic                      supply_trip_in,
  // external wake sources
  input  wire logic                      irq_pin_in,
  input  wire logic                      break_in,
  input  wire logic                      emulation_mode_in,
  input  wire logic [7:0]                keypad_pins_in,
  input  wire logic [7:0]                keypad_polarity_bits_in,
  input  wire logic                      timebase_rollover_in,
  input  wire logic                      can_bus_activity_in,
  input  wire logic                      can_sync_done_in,
  // enabled peripheral interrupt requests
  input  wire lpwc_pkg::lpwc_wake_t      wake_req_in,
  // peripheral transfer state
  input  wire logic                      serial_busy_in,
  input  wire logic                      can_busy_in,
  // configuration and crystal
  input  wire logic                      osc_run_in_stop_in,
  input  wire logic                      short_recovery_select_in,
  input  wire logic                      crystal_clock_in,
  // peripheral control
  output lpwc_pkg::lpwc_periph_ctl_t     periph_ctl_out,
  output logic                           spi_reset_out,
  output logic                           serial_data_invalid_out,
  output logic                           can_frame_invalid_out,
  output logic                           can_rx_ignore_out
);
  import lpwc_pkg::*;

  localparam int NSRC = `LPWC_SRC_COUNT;
  localparam int RW   = `LPWC_REC_WIDTH;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n;

  // asserts at once, releases two edges later
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ****************************************************************
  // edge detection
  // ****************************************************************
  logic       irq_prev_q, irq_prev_d;
  logic [7:0] kpd_prev_q, kpd_prev_d;
  logic       xtal_prev_q, xtal_prev_d;
  logic       irq_fall;
  logic       kpd_edge;
  logic       xtal_tick;

  // polarity bit set selects rising edges, clear selects falling
  always_comb begin
    irq_prev_d  = irq_pin_in;
    kpd_prev_d  = keypad_pins_in;
    xtal_prev_d = crystal_clock_in;
    irq_fall    = irq_prev_q & ~irq_pin_in; // see [R11]
    kpd_edge    = |((keypad_polarity_bits_in & keypad_pins_in & ~kpd_prev_q)
                  | (~keypad_polarity_bits_in & ~keypad_pins_in & kpd_prev_q));
    xtal_tick   = crystal_clock_in & ~xtal_prev_q;
  end

  // idle pin levels at reset so no false edge on release
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev_q  <= 1'b1;
      kpd_prev_q  <= 8'h00;
      xtal_prev_q <= 1'b0;
    end else begin
      irq_prev_q  <= irq_prev_d;
      kpd_prev_q  <= kpd_prev_d;
      xtal_prev_q <= xtal_prev_d;
    end
  end

  // ****************************************************************
  // wake events
  // ****************************************************************
  lpwc_state_t        state_q, state_d;
  lpwc_wake_t         ev;
  lpwc_wake_t         stop_mask;
  logic               rst_evt;
  logic               stop_wake;
  logic               tb_run;

  // timebase clock exists in stop only with the oscillator kept on
  assign tb_run = (state_q != LPWC_STOP) | osc_run_in_stop_in; // see [R7]

  // reset sources; the watchdog clock is gated off in stop
  assign rst_evt = ~ext_reset_n_in | supply_trip_in
                 | (watchdog_timeout_in & (state_q != LPWC_STOP)); // see [R10]

  // only these fields may end stop mode
  always_comb begin
    stop_mask          = '0;
    stop_mask.irq      = 1'b1;
    stop_mask.keypad   = 1'b1;
    stop_mask.brk      = 1'b1;
    stop_mask.timebase = 1'b1;
    stop_mask.can_wake = 1'b1;
  end

  // pins and rollovers feed their own fields, peripherals the rest
  always_comb begin
    ev          = wake_req_in; // see [R1]
    ev.brk      = break_in & emulation_mode_in; // see [R11]
    ev.irq      = irq_fall;
    ev.keypad   = kpd_edge; // see [R12]
    ev.timebase = timebase_rollover_in & tb_run; // see [R19]
    ev.can_wake = can_bus_activity_in & (state_q == LPWC_STOP);
    if (state_q == LPWC_STOP) begin
      ev = ev & stop_mask; // see [R18]
    end
  end

  assign stop_wake = |ev & (state_q == LPWC_STOP);

  // ****************************************************************
  // mode sequencer and stop recovery counter
  // ****************************************************************
  logic [RW-1:0] rec_cnt_q, rec_cnt_d;
  logic          spi_rst_q, spi_rst_d;
  logic          ser_inv_q, ser_inv_d;
  logic          can_inv_q, can_inv_d;
  logic          can_ign_q, can_ign_d;
  logic          pend_any;
  logic          stop_go;

  assign stop_go = (state_q == LPWC_RUN) & stop_instr_in & ~rst_evt;

  // recovery counts crystal edges, not core cycles
  always_comb begin
    state_d   = state_q;
    rec_cnt_d = rec_cnt_q;
    spi_rst_d = 1'b0;
    ser_inv_d = stop_go & serial_busy_in; // see [R3]
    can_inv_d = stop_go & can_busy_in; // see [R9]
    can_ign_d = can_ign_q;
    case (state_q)
      LPWC_RUN: begin
        if (stop_go) begin
          state_d = LPWC_STOP;
        end else if (wait_instr_in & ~rst_evt) begin
          state_d = LPWC_WAIT;
        end
      end
      LPWC_WAIT: begin
        if (rst_evt | pend_any | (|ev)) begin
          state_d = LPWC_RUN; // see [R1]
        end
      end
      LPWC_STOP: begin
        if (rst_evt | stop_wake) begin
          state_d   = LPWC_RECOVER;
          spi_rst_d = rst_evt; // see [R4]
          rec_cnt_d = short_recovery_select_in ? RW'(`LPWC_REC_SHORT_CYC - 1)
                                               : RW'(`LPWC_REC_LONG_CYC - 1); // see [R22]
        end
      end
      LPWC_RECOVER: begin
        if (xtal_tick) begin
          if (rec_cnt_q == '0) begin
            state_d = LPWC_RUN; // see [R21]
          end else begin
            rec_cnt_d = rec_cnt_q - 1'b1;
          end
        end
      end
      default: begin
        state_d = LPWC_RUN;
      end
    endcase
    // bus activity wake: ignore data until resynchronised, set wins
    if ((state_q == LPWC_RUN) & can_sync_done_in) begin
      can_ign_d = 1'b0;
    end
    if ((state_q == LPWC_STOP) & can_bus_activity_in) begin
      can_ign_d = 1'b1; // see [R20]
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= LPWC_RUN;
      rec_cnt_q <= '0;
      spi_rst_q <= 1'b0;
      ser_inv_q <= 1'b0;
      can_inv_q <= 1'b0;
      can_ign_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      rec_cnt_q <= rec_cnt_d;
      spi_rst_q <= spi_rst_d;
      ser_inv_q <= ser_inv_d;
      can_inv_q <= can_inv_d;
      can_ign_q <= can_ign_d;
    end
  end

  // ****************************************************************
  // pending wake requests and vector presentation
  // ****************************************************************
  logic [NSRC-1:0] pend_q, pend_d;
  logic            rst_pend_q, rst_pend_d;
  logic            vec_valid_q, vec_valid_d;
  logic [15:0]     vec_addr_q, vec_addr_d;
  logic            vec_rst_q, vec_rst_d;
  logic [4:0]      vec_idx_q, vec_idx_d;
  logic            fetch;
  logic            pick_any;
  logic [4:0]      pick_idx;
  logic [15:0]     pick_addr;

  assign fetch    = vector_fetched_in & vec_valid_q;
  assign pend_any = |pend_q | rst_pend_q;

  lpwc_vector_pick u_pick (
    .pend_in  (pend_q),
    .any_out  (pick_any),
    .idx_out  (pick_idx),
    .addr_out (pick_addr)
  );

  // a reset wipes older requests; new events always win over a clear
  always_comb begin
    pend_d     = pend_q;
    rst_pend_d = rst_pend_q;
    if (fetch & vec_rst_q) begin
      rst_pend_d = 1'b0;
    end
    if (fetch & ~vec_rst_q) begin
      pend_d[vec_idx_q] = 1'b0; // see [R23]
    end
    if (rst_evt) begin
      pend_d     = '0;
      rst_pend_d = 1'b1; // see [R10]
    end
    pend_d = pend_d | NSRC'(ev); // see [R23]
    // valid drops for a cycle after each fetch so no stale pair repeats
    vec_valid_d = (state_q == LPWC_RUN) & ~fetch & (rst_pend_q | pick_any);
    vec_rst_d   = rst_pend_q;
    vec_idx_d   = pick_idx;
    vec_addr_d  = rst_pend_q ? `LPWC_VEC_RESET : pick_addr;
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pend_q      <= '0;
      rst_pend_q  <= 1'b0;
      vec_valid_q <= 1'b0;
      vec_addr_q  <= 16'h0000;
      vec_rst_q   <= 1'b0;
      vec_idx_q   <= 5'h00;
    end else begin
      pend_q      <= pend_d;
      rst_pend_q  <= rst_pend_d;
      vec_valid_q <= vec_valid_d;
      vec_addr_q  <= vec_addr_d;
      vec_rst_q   <= vec_rst_d;
      vec_idx_q   <= vec_idx_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // peripheral clocks follow the mode; registers are kept, except the spi reset on a reset exit from stop
  always_comb begin
    periph_ctl_out                 = '0;
    periph_ctl_out.serial_run      = (state_q == LPWC_RUN) | (state_q == LPWC_WAIT); // see [R2]
    periph_ctl_out.spi_run         = (state_q == LPWC_RUN) | (state_q == LPWC_WAIT); // see [R4]
    periph_ctl_out.timer_run       = (state_q == LPWC_RUN) | (state_q == LPWC_WAIT); // see [R5]
    periph_ctl_out.timebase_run    = tb_run & (state_q != LPWC_RECOVER); // see [R6]
    periph_ctl_out.timebase_access = (state_q == LPWC_RUN); // see [R6]
    periph_ctl_out.can_run         = (state_q == LPWC_RUN) | (state_q == LPWC_WAIT); // see [R8]
    periph_ctl_out.can_access      = (state_q == LPWC_RUN); // see [R8]
  end

  assign vector_valid_out        = vec_valid_q;
  assign vector_addr_out         = vec_addr_q;
  assign reset_req_out           = rst_pend_q;
  assign cpu_clock_run_out       = (state_q == LPWC_RUN);
  assign system_clock_run_out    = (state_q == LPWC_RUN) | (state_q == LPWC_WAIT); // see [R21]
  assign state_out               = state_q;
  assign spi_reset_out           = spi_rst_q;
  assign serial_data_invalid_out = ser_inv_q;
  assign can_frame_invalid_out   = can_inv_q;
  assign can_rx_ignore_out       = can_ign_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [RW:0] rec_ticks_q;
  logic        rec_short_q;

  // crystal edges seen in recovery, for the length check only
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rec_ticks_q <= '0;
      rec_short_q <= 1'b0;
    end else if (state_q != LPWC_RECOVER) begin
      rec_ticks_q <= '0;
      rec_short_q <= short_recovery_select_in;
    end else if (xtal_tick) begin
      rec_ticks_q <= rec_ticks_q + 1'b1;
    end
  end

  chk_wait_serial_on: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R1]
    (state_q == LPWC_WAIT && wake_req_in.serial_rx) |=> (state_q == LPWC_RUN))
    else $error("serial request did not end wait");
  chk_stop_serial_off: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R2]
    (state_q == LPWC_STOP) |-> !periph_ctl_out.serial_run && !system_clock_run_out)
    else $error("serial port clocked in stop");
  chk_serial_invalid: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R3]
    (state_q == LPWC_RUN && stop_instr_in && serial_busy_in && ext_reset_n_in
     && !supply_trip_in && !watchdog_timeout_in) |=> serial_data_invalid_out)
    else $error("serial data not flagged invalid");
  chk_spi_reset: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R4]
    (state_q == LPWC_STOP && !ext_reset_n_in) |=> spi_reset_out && state_q == LPWC_RECOVER)
    else $error("spi not reset on reset exit");
  chk_timer_freeze: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R5]
    (state_q != LPWC_RUN) |-> (periph_ctl_out.timer_run == (state_q == LPWC_WAIT)))
    else $error("timer run wrong for mode");
  chk_tb_wait_access: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R6]
    (state_q == LPWC_WAIT) |-> periph_ctl_out.timebase_run && !periph_ctl_out.timebase_access)
    else $error("timebase access in wait");
  chk_tb_stop_osc: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R7]
    (state_q == LPWC_STOP) |-> (periph_ctl_out.timebase_run == osc_run_in_stop_in)
    && !periph_ctl_out.timebase_access)
    else $error("timebase stop behaviour wrong");
  chk_can_wait_block: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R8]
    (state_q == LPWC_WAIT) |-> periph_ctl_out.can_run && !periph_ctl_out.can_access)
    else $error("can register access in wait");
  chk_reset_vector: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R10]
    (vector_valid_out && reset_req_out) |-> vector_addr_out == 16'hFFFE)
    else $error("reset vector address wrong");
  chk_can_ignore: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R20]
    (state_q == LPWC_STOP && can_bus_activity_in) |=> can_rx_ignore_out [*2])
    else $error("can data not ignored after wake");
  chk_recover_len: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R21]
    (state_q == LPWC_RECOVER && state_d == LPWC_RUN) |->
    (rec_ticks_q + 1'b1 == (rec_short_q ? 13'd32 : 13'd4096)))
    else $error("stop recovery length wrong");
  chk_pend_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n) // see [R23]
    (!fetch && !rst_evt) |=> ((pend_q & $past(pend_q)) == $past(pend_q)))
    else $error("pending wake lost without fetch");

endmodule : lpwc_wake_ctrl

// ==== rtl/lpwc_map.svh ====
// constants for the low-power wake control block
`ifndef LPWC_MAP_SVH
`define LPWC_MAP_SVH
// How it works
// [R1] serial port runs in wait, its requests wake
// [R2] serial port halts in stop, registers kept
// [R3] stop entry mid-transfer flags serial data invalid
// [R4] spi holds in stop, reset exit resets it
// [R5] timers run in wait, freeze in stop
// [R6] timebase runs in wait, no cpu access
// [R7] timebase runs in stop only with oscillator on
// [R8] can runs in wait, registers blocked
// [R9] can halts in stop, active frame invalid
// [R10] reset pin, watchdog, supply trip give FFFE
// [R11] irq falling edge FFFA, emulation break FFFC
// [R12] clkgen FFF8, keypad FFE0, converter FFDE, timebase FFDC
// [R13] first timer vectors FFF2, FFF4, FFF6
// [R14] second timer vectors FFEC..FFF0 and FFCC..FFD2
// [R15] spi transmitter FFE8, receiver FFEA
// [R16] serial tx FFE2, rx FFE4, error FFE6
// [R17] can tx FFD4, rx FFD6, error FFD8, wake FFDA
// [R18] only listed events end stop mode
// [R19] timebase rollover wakes from stop periodically
// [R20] can ignores data until bus synchronised
// [R21] stop exit holds clocks 4096 crystal cycles
// [R22] short recovery select gives 32 cycles
// [R23] wake requests pend until vector fetched or a reset clears them

// core clock period, ns
`define LPWC_CLK_PERIOD_NS   8
// reset vector pair high address
`define LPWC_VEC_RESET       16'hFFFE
// highest interrupt vector; each lower source sits two bytes down
`define LPWC_VEC_TOP         16'hFFFC
// number of interrupt wake sources
`define LPWC_SRC_COUNT       25
// stop recovery counter width and lengths in crystal cycles
`define LPWC_REC_WIDTH       12
`define LPWC_REC_LONG_CYC    4096
`define LPWC_REC_SHORT_CYC   32
`endif

// ==== rtl/lpwc_pkg.sv ====
// types shared by the low-power wake control block
package lpwc_pkg;

  // power mode; gray order run, wait, stop, recover
  typedef enum logic [1:0] {
    LPWC_RUN     = 2'h0,
    LPWC_WAIT    = 2'h1,
    LPWC_STOP    = 2'h3,
    LPWC_RECOVER = 2'h2
  } lpwc_state_t;

  // one bit per interrupt source, bit 0 has the highest priority
  typedef struct packed {
    logic t2_ch5;
    logic t2_ch4;
    logic t2_ch3;
    logic t2_ch2;
    logic can_tx;
    logic can_rx;
    logic can_err;
    logic can_wake;
    logic timebase;
    logic converter;
    logic keypad;
    logic serial_tx;
    logic serial_rx;
    logic serial_err;
    logic spi_tx;
    logic spi_rx;
    logic t2_ovf;
    logic t2_ch1;
    logic t2_ch0;
    logic t1_ovf;
    logic t1_ch1;
    logic t1_ch0;
    logic clkgen;
    logic irq;
    logic brk;
  } lpwc_wake_t;

  // run and access enables for the peripherals
  typedef struct packed {
    logic serial_run;
    logic spi_run;
    logic timer_run;
    logic timebase_run;
    logic timebase_access;
    logic can_run;
    logic can_access;
  } lpwc_periph_ctl_t;

endpackage : lpwc_pkg

// ==== rtl/lpwc_vector_pick.sv ====
// priority pick of the pending wake source and its vector address
`timescale 1ns/10ps
`include "lpwc_map.svh"
module lpwc_vector_pick (
  // pending sources
  input  wire logic [`LPWC_SRC_COUNT-1:0] pend_in,
  // chosen source
  output logic                            any_out,
  output logic [4:0]                      idx_out,
  output logic [15:0]                     addr_out
);
  import lpwc_pkg::*;

  // vector of a source: pairs descend two bytes per priority step
  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    vec_of = `LPWC_VEC_TOP - {10'h000, idx, 1'b0}; // see [R11] [R12] [R13] [R14]
  endfunction : vec_of

  // lowest index wins; the loop runs high to low so the last hit stays
  always_comb begin
    any_out = 1'b0;
    idx_out = 5'h00;
    for (int i = `LPWC_SRC_COUNT - 1; i >= 0; i--) begin
      if (pend_in[i]) begin
        any_out = 1'b1;
        idx_out = 5'(i);
      end
    end
    addr_out = vec_of(idx_out); // see [R15] [R16] [R17]
  end

  // bit 24 of the wake layout must land on the last pair
  chk_vec_bottom: assert property (@(posedge any_out) (vec_of(5'd24) == 16'hFFCC)) // see [R14]
    else $error("lowest vector pair misplaced");

endmodule : lpwc_vector_pick

// ==== tb/lpwc_cpu_model.sv ====
// cpu core model: crystal source and vector fetch responder
`timescale 1ns/10ps
module lpwc_cpu_model (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // vector handshake
  input  wire logic       valid_in,
  input  wire logic [1:0] lat_in,
  output logic            fetched_out,
  // crystal oscillator
  output logic            xtal_out
);
  logic [1:0] wait_q;
  // fetch after a chosen latency; strobe is one cycle so no vector is taken twice
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fetched_out <= 1'b0;
      wait_q      <= 2'h0;
      xtal_out    <= 1'b0;
    end else begin
      xtal_out <= ~xtal_out;
      if (fetched_out || !valid_in) begin
        fetched_out <= 1'b0;
        wait_q      <= 2'h0;
      end else if (wait_q == lat_in) begin
        fetched_out <= 1'b1;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : lpwc_cpu_model

// ==== tb/lpwc_wake_ctrl_bench.sv ====
// self-checking bench for the low-power wake control block
`timescale 1ns/10ps
module lpwc_wake_ctrl_bench;
  import lpwc_pkg::*;
  // ************************************************************
  // signals and bench state
  // ************************************************************
  logic core_clk_in = 1'b0;
  logic rstn_in, wait_instr_in, stop_instr_in, vector_fetched_in;
  logic vector_valid_out, reset_req_out, cpu_clock_run_out, system_clock_run_out;
  logic ext_reset_n_in, watchdog_timeout_in, supply_trip_in, irq_pin_in, break_in;
  logic emulation_mode_in, timebase_rollover_in, can_bus_activity_in, can_sync_done_in;
  logic serial_busy_in, can_busy_in, osc_run_in_stop_in, short_recovery_select_in;
  logic crystal_clock_in, spi_reset_out, serial_data_invalid_out, can_frame_invalid_out;
  logic can_rx_ignore_out, xprev;
  logic [15:0]      vector_addr_out;
  logic [7:0]       keypad_pins_in, keypad_polarity_bits_in;
  logic [1:0]       lat;
  logic [24:0]      m;
  lpwc_state_t      state_out;
  lpwc_wake_t       wake_req_in;
  lpwc_periph_ctl_t periph_ctl_out;
  int err_count = 0, checked = 0, n_spi = 0, n_sdi = 0, n_cfi = 0, n_edge = 0;
  int sh, b1, b2, e0, p0, s0, c0, i;
  // vector of each wake source, bit 0 first
  logic [15:0] vt [25] = '{16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2,
    16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2,
    16'hFFE0, 16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4, 16'hFFD2,
    16'hFFD0, 16'hFFCE, 16'hFFCC};
  // vector expected for each stop exit event
  logic [15:0] ex [6] = '{16'hFFFA, 16'hFFE0, 16'hFFFC, 16'hFFDC, 16'hFFDA, 16'hFFFE};

  lpwc_wake_ctrl i_dut (
    .core_clk_in, .rstn_in, .wait_instr_in, .stop_instr_in, .vector_fetched_in,
    .vector_valid_out, .vector_addr_out, .reset_req_out, .cpu_clock_run_out,
    .system_clock_run_out, .state_out, .ext_reset_n_in, .watchdog_timeout_in,
    .supply_trip_in, .irq_pin_in, .break_in, .emulation_mode_in, .keypad_pins_in,
    .keypad_polarity_bits_in, .timebase_rollover_in, .can_bus_activity_in,
    .can_sync_done_in, .wake_req_in, .serial_busy_in, .can_busy_in, .osc_run_in_stop_in,
    .short_recovery_select_in, .crystal_clock_in, .periph_ctl_out, .spi_reset_out,
    .serial_data_invalid_out, .can_frame_invalid_out, .can_rx_ignore_out
  );
  lpwc_cpu_model i_cpu (
    .clk_in(core_clk_in), .rstn_in, .valid_in(vector_valid_out), .lat_in(lat),
    .fetched_out(vector_fetched_in), .xtal_out(crystal_clock_in)
  );

  // ************************************************************
  // clock, pulse counters and tasks
  // ************************************************************
  always #4 core_clk_in = ~core_clk_in;
  // pulses are counted, so a short pulse is never missed between checks
  always @(posedge core_clk_in) begin
    n_spi <= n_spi + spi_reset_out;
    n_sdi <= n_sdi + serial_data_invalid_out;
    n_cfi <= n_cfi + can_frame_invalid_out;
    xprev <= crystal_clock_in;
    if (state_out == LPWC_RECOVER && crystal_clock_in && !xprev) n_edge <= n_edge + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cyc
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // wait for the model's fetch strobe; values read are those before the edge
  task automatic fetch(input logic [15:0] exp);
    for (i = 0; i < 9000 && vector_fetched_in !== 1'b1; i++) @(posedge core_clk_in);
    check("fetch seen", 16'(i < 9000), 16'h0001);
    check("vector", vector_addr_out, exp);
    @(posedge core_clk_in);
  endtask : fetch
  task automatic results();
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // watchdog: whole run is well under this many cycles
  initial begin
    #(8 * 90000);
    err_count++;
    results();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {rstn_in, wait_instr_in, stop_instr_in, watchdog_timeout_in} = '0;
    {supply_trip_in, break_in, timebase_rollover_in, can_bus_activity_in} = '0;
    {can_sync_done_in, serial_busy_in, can_busy_in, osc_run_in_stop_in} = '0;
    {short_recovery_select_in, keypad_pins_in, lat, m} = '0;
    {ext_reset_n_in, irq_pin_in, emulation_mode_in} = 3'h7;
    keypad_polarity_bits_in = 8'hFF;
    wake_req_in = '0;
    void'($urandom(32'h57AA_622D));
    cyc(5);
    rstn_in <= 1'b1;
    cyc(4);
    check("reset state", 16'(state_out), 16'(LPWC_RUN));
    check("reset ctl", 16'({periph_ctl_out, vector_valid_out}), 16'h00FE);
    // wait: serial port keeps running and its request ends the mode
    wait_instr_in <= 1'b1;
    cyc(1);
    wait_instr_in <= 1'b0;
    cyc(1);
    check("wait clocks", 16'({state_out, cpu_clock_run_out, system_clock_run_out}),
          16'h0005);
    check("wait ctl", 16'(periph_ctl_out), 16'h007A);
    wake_req_in.serial_rx <= 1'b1;
    cyc(1);
    wake_req_in.serial_rx <= 1'b0;
    fetch(16'hFFE4);
    // every reset source gives the reset vector
    for (int s = 0; s < 3; s++) begin
      ext_reset_n_in <= (s != 0);
      watchdog_timeout_in <= (s == 1);
      supply_trip_in <= (s == 2);
      cyc(1);
      {watchdog_timeout_in, supply_trip_in, ext_reset_n_in} <= 3'h1;
      cyc(1);
      check("reset request", 16'(reset_req_out), 16'h0001);
      fetch(16'hFFFE);
    end
    // random request sets come out in priority order, first set has all 20 peripheral requests
    for (int n = 0; n < 12; n++) begin
      m = (n == 0) ? 25'h1FC_BFFC : (25'($urandom) & 25'h1FC_BFFC);
      lat <= 2'($urandom_range(3));
      wake_req_in <= lpwc_wake_t'(m);
      cyc(1);
      wake_req_in <= '0;
      for (int j = 0; j < 25; j++) begin
        if (m[j]) fetch(vt[j]);
      end
    end
    // stop entry, one exit event each, recovery length counted in crystal edges
    for (int k = 0; k < 6; k++) begin
      sh = (k == 5) ? 0 : $urandom_range(1);
      b1 = $urandom_range(1);
      b2 = $urandom_range(1);
      {s0, c0, p0} = {n_sdi, n_cfi, n_spi};
      {osc_run_in_stop_in, short_recovery_select_in} <= {k == 3, sh[0]};
      {serial_busy_in, can_busy_in, stop_instr_in} <= {b1[0], b2[0], 1'b1};
      cyc(1);
      {serial_busy_in, can_busy_in, stop_instr_in} <= 3'h0;
      // masked requests and a gated watchdog must not end stop
      {wake_req_in.t1_ovf, wake_req_in.converter, watchdog_timeout_in} <= 3'h7;
      cyc(1);
      check("stop state", 16'(state_out), 16'(LPWC_STOP));
      check("stop ctl", 16'(periph_ctl_out),
            (k == 3) ? 16'h0008 : 16'h0000);
      cyc(3);
      check("stop holds", 16'({state_out, vector_valid_out}), 16'h0006);
      {wake_req_in.t1_ovf, wake_req_in.converter, watchdog_timeout_in} <= 3'h0;
      e0 = n_edge;
      case (k)
        0: irq_pin_in <= 1'b0;
        1: keypad_pins_in[$urandom_range(7)] <= 1'b1;
        2: break_in <= 1'b1;
        3: timebase_rollover_in <= 1'b1;
        4: can_bus_activity_in <= 1'b1;
        default: ext_reset_n_in <= 1'b0;
      endcase
      cyc(1);
      {break_in, timebase_rollover_in, can_bus_activity_in, keypad_pins_in} <= '0;
      {irq_pin_in, ext_reset_n_in} <= 2'h3;
      for (i = 0; i < 9000 && state_out !== LPWC_RUN; i++) cyc(1);
      check("recovery done", 16'(state_out), 16'(LPWC_RUN));
      check("recovery edges", 16'(n_edge - e0), sh ? 16'h0020 : 16'h1000);
      if (k == 4) check("can ignore", 16'(can_rx_ignore_out), 16'h0001);
      fetch(ex[k]);
      can_sync_done_in <= 1'b1;
      cyc(2);
      can_sync_done_in <= 1'b0;
      check("can ignore end", 16'(can_rx_ignore_out), 16'h0000);
      check("spi reset", 16'(n_spi - p0), 16'(k == 5));
      check("serial invalid", 16'(n_sdi - s0), 16'(b1));
      check("can invalid", 16'(n_cfi - c0), 16'(b2));
    end
    results();
  end
endmodule : lpwc_wake_ctrl_bench
